/* File: hw/pif_irq_slice.sv */
// flag register 10, enable registers 0 to 3, request gating and an ahb-lite slave
//
// The register addresses and the AHB-Lite interface to the registers were decided locally.
`timescale 1ns/100ps

module pif_irq_slice
    import pif_pkg::*;
(
    input  wire logic                            hclk,
    input  wire logic                            hresetn,

    // ahb-lite slave; hready ties to hreadyout
    input  wire logic                            hsel,
    input  wire logic [31:0]                     haddr,
    input  wire logic [1:0]                      htrans,
    input  wire logic                            hwrite,
    // hsize is not decoded
    input  wire logic [2:0]                      hsize,
    input  wire logic [pif_pkg::PIF_DATA_W-1:0]  hwdata,
    input  wire logic                            hready,
    output logic                                 hreadyout,
    output logic                                 hresp,
    output logic      [pif_pkg::PIF_DATA_W-1:0]  hrdata,

    // events of the two sources whose flags live here
    // each high cycle is one event
    input  wire logic                            logic_cell4_event,
    input  wire logic                            capcomp4_event,
    output logic                                 logic_cell4_event_flag,
    output logic                                 capcomp4_event_flag,

    // flags of the sources covered by enable registers 0 to 3
    input  wire logic [pif_pkg::PIF_REG_W-1:0]   src_flag_0,
    input  wire logic [pif_pkg::PIF_REG_W-1:0]   src_flag_1,
    input  wire logic [pif_pkg::PIF_REG_W-1:0]   src_flag_2,
    input  wire logic [pif_pkg::PIF_REG_W-1:0]   src_flag_3,

    // gated requests toward the vectored interrupt logic
    output logic      [pif_pkg::PIF_REG_W-1:0]   irq_req_0,
    output logic      [pif_pkg::PIF_REG_W-1:0]   irq_req_1,
    output logic      [pif_pkg::PIF_REG_W-1:0]   irq_req_2,
    output logic      [pif_pkg::PIF_REG_W-1:0]   irq_req_3,

    // summary interrupt from the sticky status and mask
    output logic                                 irq
);
    import pif_pkg::*;

    // ------------------------------------------------------------------
    // declarations
    // ------------------------------------------------------------------
    // read-bus zero fill
    localparam int PAD_W = PIF_DATA_W - PIF_REG_W;

    // address-phase decode
    logic                    addr_take;
    logic                    rd_take;
    logic [PIF_ADDR_W-1:0]   a_addr;

    // write data phase
    logic                    dp_wr;
    logic [PIF_ADDR_W-1:0]   dp_addr;

    // register strobes
    logic                    wr_flags;
    logic                    wr_mask;
    logic                    rd_status;

    // event flags
    logic [PIF_FLAG10_W-1:0] ev_vec;
    logic [PIF_FLAG10_W-1:0] flags10;
    logic [PIF_FLAG10_W-1:0] next_flags10;

    // status and mask
    logic [PIF_STAT_W-1:0]   status;
    logic [PIF_STAT_W-1:0]   status_view;
    logic [PIF_STAT_W-1:0]   status_clr;
    logic [PIF_STAT_W-1:0]   mask;
    logic [PIF_STAT_W-1:0]   next_mask;

    // enable banks
    logic [PIF_REG_W-1:0]    en        [PIF_NUM_EN];
    logic [PIF_REG_W-1:0]    next_en   [PIF_NUM_EN];
    logic [PIF_REG_W-1:0]    src_flags [PIF_NUM_EN];
    logic [PIF_REG_W-1:0]    req       [PIF_NUM_EN];
    logic [PIF_REG_W-1:0]    en_or     [PIF_NUM_EN+1];

    // read path
    logic [PIF_REG_W-1:0]    rd_view;
    logic                    hit_flags;
    logic                    hit_status;
    logic                    hit_mask;

    // a register wider than the bus, or a status unlike the flags,
    // cannot be served by this slice
    if (PIF_REG_W > PIF_DATA_W || PIF_FLAG10_W > PIF_REG_W) begin : g_bad_width
        $error("register wider than the bus");
    end
    if (PIF_STAT_W != PIF_FLAG10_W) begin : g_bad_stat
        $error("status unlike the flag register");
    end

    // ------------------------------------------------------------------
    // ahb-lite address phase and decode
    // ------------------------------------------------------------------

    // a transfer is taken when selected, ready and nonseq/seq
    // seq counts as nonseq
    assign addr_take = hsel & hready & htrans[1];
    assign rd_take   = addr_take & ~hwrite;

    // upper bits not decoded
    assign a_addr    = haddr[PIF_ADDR_W-1:0];

    // zero wait states; the response is always okay
    // unmapped offsets answer okay too
    assign hreadyout = 1'b1;
    assign hresp     = 1'b0;

    // write data arrives one cycle after its address
    // dp_addr loads every cycle; dp_wr gates it
    // reset drops dp_wr: no stray write
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            dp_wr   <= 1'b0;
            dp_addr <= '0;
        end else begin
            dp_wr   <= addr_take & hwrite;
            dp_addr <= a_addr;
        end
    end

    // data-phase write strobes; unmapped offsets are simply ignored
    // hwdata stands in this cycle
    assign wr_flags = dp_wr & (dp_addr == PIF_OFS_FLAGS10);
    assign wr_mask  = dp_wr & (dp_addr == PIF_OFS_MASK);

    // address-phase read hits; hsize is not checked, only words are issued
    assign hit_flags  = rd_take & (a_addr == PIF_OFS_FLAGS10);
    assign hit_status = rd_take & (a_addr == PIF_OFS_STATUS);
    assign hit_mask   = rd_take & (a_addr == PIF_OFS_MASK);

    // status clears on its read's address
    assign rd_status  = hit_status;

    // ------------------------------------------------------------------
    // event flag register 10
    // ------------------------------------------------------------------

    // events set their flag with no regard to any enable
    // same-clock inputs: no synchroniser
    assign ev_vec[PIF_CAPCOMP4_BIT]    = capcomp4_event;
    assign ev_vec[PIF_LOGIC_CELL4_BIT] = logic_cell4_event;

    // software write loads the bits; writing 0 is the only clear
    // clr stays idle
    pif_sticky_bits #(
        .W        (PIF_FLAG10_W)
    ) u_flags10 (
        .hclk     (hclk),
        .hresetn  (hresetn),
        .set      (ev_vec),
        .load     (wr_flags),
        .load_val (hwdata[PIF_FLAG10_W-1:0]),
        .clr      ('0),
        .q        (flags10),
        .next_q   (next_flags10)
    );

    // flags leave as levels
    assign capcomp4_event_flag    = flags10[PIF_CAPCOMP4_BIT];
    assign logic_cell4_event_flag = flags10[PIF_LOGIC_CELL4_BIT];

    // ------------------------------------------------------------------
    // enable registers 0 to 3 and request gating
    // ------------------------------------------------------------------
    // array form for the bank loop
    assign src_flags[0] = src_flag_0;
    assign src_flags[1] = src_flag_1;
    assign src_flags[2] = src_flag_2;
    assign src_flags[3] = src_flag_3;

    // chain starts at zero
    assign en_or[0]     = '0;

    // one register per bank; the field order is fixed by the package
    // bit positions
    for (genvar i = 0; i < PIF_NUM_EN; i++) begin : g_en
        // fixed stride between banks
        localparam logic [PIF_ADDR_W-1:0] OFS =
            PIF_ADDR_W'(PIF_OFS_EN0 + PIF_OFS_STRIDE * PIF_ADDR_W'(i));

        // this bank's decode
        logic wr_en;
        logic hit_en;

        assign wr_en  = dp_wr & (dp_addr == OFS);
        assign hit_en = rd_take & (a_addr == OFS);

        // full read/write, zero on reset
        // low byte of hwdata only
        pif_rw_reg #(
            .W       (PIF_REG_W),
            .RESET   (PIF_EN_RESET)
        ) u_en (
            .hclk    (hclk),
            .hresetn (hresetn),
            .wr      (wr_en),
            .wr_val  (hwdata[PIF_REG_W-1:0]),
            .q       (en[i]),
            .next_q  (next_en[i])
        );

        // a request stands only while flag and enable are both set
        // the flag is held by the source
        assign req[i] = src_flags[i] & en[i];

        // read view uses the post-write value so a read right after a write is fresh
        // idle banks add zero: a mux
        assign en_or[i+1] = en_or[i] | ({PIF_REG_W{hit_en}} & next_en[i]);
    end

    // enable gating alone decides; stale flags are software's concern
    // no delay from flag to request
    assign irq_req_0 = req[0];
    assign irq_req_1 = req[1];
    assign irq_req_2 = req[2];
    assign irq_req_3 = req[3];

    // ------------------------------------------------------------------
    // sticky status, mask and summary interrupt
    // ------------------------------------------------------------------

    // a read of status clears it, but an event in that cycle survives
    // records events, not how many
    assign status_clr = {PIF_STAT_W{rd_status}};

    pif_sticky_bits #(
        .W        (PIF_STAT_W)
    ) u_status (
        .hclk     (hclk),
        .hresetn  (hresetn),
        .set      (ev_vec),
        .load     (1'b0),
        .load_val ('0),
        .clr      (status_clr),
        .q        (status),
        .next_q   ()
    );

    // mask 1 lets status reach irq
    pif_rw_reg #(
        .W       (PIF_STAT_W),
        .RESET   (PIF_STAT_RESET)
    ) u_mask (
        .hclk    (hclk),
        .hresetn (hresetn),
        .wr      (wr_mask),
        .wr_val  (hwdata[PIF_STAT_W-1:0]),
        .q       (mask),
        .next_q  (next_mask)
    );

    // a status read shows this cycle's events
    assign status_view = status | ev_vec;

    // level output, combinational from flops so it drops with the read
    // only sticky status feeds irq
    assign irq = |(status & mask);

    // ------------------------------------------------------------------
    // read data
    // ------------------------------------------------------------------

    // upper flag bits and unmapped offsets read as zero
    // one hit at most: or acts as mux
    assign rd_view =
        ({PIF_REG_W{hit_flags}}  & PIF_REG_W'(next_flags10)) |
        ({PIF_REG_W{hit_status}} & PIF_REG_W'(status_view)) |
        ({PIF_REG_W{hit_mask}}   & PIF_REG_W'(next_mask)) |
        en_or[PIF_NUM_EN];

    // registered so the data phase sees a stable word
    // a write reloads zero
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hrdata <= '0;
        end else if (addr_take) begin
            hrdata <= {{PAD_W{1'b0}}, rd_view};
        end
    end

endmodule

/* File: hw/pif_pkg.sv */
// constants shared by the peripheral interrupt flag and enable slice
package pif_pkg;

    // ------------------------------------------------------------------
    // bus and register widths
    // ------------------------------------------------------------------
    localparam int PIF_DATA_W   = 32;
    localparam int PIF_ADDR_W   = 8;
    localparam int PIF_REG_W    = 8;
    localparam int PIF_FLAG10_W = 2;
    localparam int PIF_NUM_EN   = 4;
    localparam int PIF_STAT_W   = 2;

    // ------------------------------------------------------------------
    // byte offsets of the registers on the bus
    // ------------------------------------------------------------------
    localparam logic [PIF_ADDR_W-1:0] PIF_OFS_FLAGS10 = 8'h00;
    localparam logic [PIF_ADDR_W-1:0] PIF_OFS_EN0     = 8'h04;
    localparam logic [PIF_ADDR_W-1:0] PIF_OFS_STRIDE  = 8'h04;
    localparam logic [PIF_ADDR_W-1:0] PIF_OFS_STATUS  = 8'h14;
    localparam logic [PIF_ADDR_W-1:0] PIF_OFS_MASK    = 8'h18;

    // ------------------------------------------------------------------
    // reset values
    // ------------------------------------------------------------------
    localparam logic [PIF_REG_W-1:0]    PIF_EN_RESET     = 8'h00;
    localparam logic [PIF_FLAG10_W-1:0] PIF_FLAG10_RESET = 2'h0;
    localparam logic [PIF_STAT_W-1:0]   PIF_STAT_RESET   = 2'h0;

    // ------------------------------------------------------------------
    // flag register 10 and status/mask bit positions
    // ------------------------------------------------------------------
    localparam int PIF_CAPCOMP4_BIT    = 0;
    localparam int PIF_LOGIC_CELL4_BIT = 1;

    // ------------------------------------------------------------------
    // enable register 0 fields
    // ------------------------------------------------------------------
    localparam int PIN_CHANGE_IRQ_EN    = 7;
    localparam int CHECKSUM_IRQ_EN      = 6;
    localparam int MEM_SCANNER_IRQ_EN   = 5;
    localparam int NONVOLATILE_IRQ_EN   = 4;
    localparam int CLK_SWITCH_IRQ_EN    = 3;
    localparam int OSC_FAIL_IRQ_EN      = 2;
    localparam int VOLTAGE_DETECT_IRQ_EN = 1;
    localparam int SOFT_IRQ_EN          = 0;

    // ------------------------------------------------------------------
    // enable register 1 fields
    // ------------------------------------------------------------------
    localparam int MEAS_TIMER_PULSE_WIDTH_IRQ_EN = 7;
    localparam int MEAS_TIMER_PERIOD_IRQ_EN      = 6;
    localparam int MEAS_TIMER_IRQ_EN             = 5;
    localparam int COMPARATOR_ONE_IRQ_EN         = 4;
    localparam int ADC_THRESHOLD_IRQ_EN          = 3;
    localparam int ADC_DONE_IRQ_EN               = 2;
    localparam int ZERO_CROSS_IRQ_EN             = 1;
    localparam int EXT_PIN_ZERO_IRQ_EN           = 0;

    // ------------------------------------------------------------------
    // enable register 2 fields
    // ------------------------------------------------------------------
    localparam int FIRST_I2C_RX_IRQ_EN        = 7;
    localparam int FIRST_SPI_IRQ_EN           = 6;
    localparam int FIRST_SPI_TX_IRQ_EN        = 5;
    localparam int FIRST_SPI_RX_IRQ_EN        = 4;
    localparam int FIRST_DMA_ABORT_IRQ_EN     = 3;
    localparam int FIRST_DMA_OVERRUN_IRQ_EN   = 2;
    localparam int FIRST_DMA_DST_COUNT_IRQ_EN = 1;
    localparam int FIRST_DMA_SRC_COUNT_IRQ_EN = 0;

    // ------------------------------------------------------------------
    // enable register 3 fields
    // ------------------------------------------------------------------
    localparam int TIMER_ZERO_IRQ_EN         = 7;
    localparam int FIRST_UART_IRQ_EN         = 6;
    localparam int FIRST_UART_FRAMING_IRQ_EN = 5;
    localparam int FIRST_UART_TX_IRQ_EN      = 4;
    localparam int FIRST_UART_RX_IRQ_EN      = 3;
    localparam int FIRST_I2C_ERROR_IRQ_EN    = 2;
    localparam int FIRST_I2C_IRQ_EN          = 1;
    localparam int FIRST_I2C_TX_IRQ_EN       = 0;

endpackage

/* File: hw/pif_rw_reg.sv */
// plain read/write register with a zero reset and a look-ahead value
`timescale 1ns/100ps
module pif_rw_reg #(
    parameter int             W     = 8,
    parameter logic [W-1:0]   RESET = '0
) (
    input  wire logic         hclk,
    input  wire logic         hresetn,
    input  wire logic         wr,
    input  wire logic [W-1:0] wr_val,
    output logic      [W-1:0] q,
    output logic      [W-1:0] next_q
);

    // a write replaces the whole value; otherwise hold
    assign next_q = wr ? wr_val : q;

    // every bit loads the RESET value on reset
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            q <= RESET;
        end else begin
            q <= next_q;
        end
    end

endmodule

/* File: hw/pif_sticky_bits.sv */
// hardware-set bits that software may load or clear; a set always wins
`timescale 1ns/100ps
module pif_sticky_bits #(
    parameter int             W = 2
) (
    input  wire logic         hclk,
    input  wire logic         hresetn,
    input  wire logic [W-1:0] set,
    input  wire logic         load,
    input  wire logic [W-1:0] load_val,
    input  wire logic [W-1:0] clr,
    output logic      [W-1:0] q,
    output logic      [W-1:0] next_q
);

    // or-ing the set last keeps an event that lands on a clear
    assign next_q = ((load ? load_val : q) & ~clr) | set;

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            q <= '0;
        end else begin
            q <= next_q;
        end
    end

endmodule

/* File: verif/pif_irq_slice_chk.sv */
// concurrent checks on the ports of the peripheral interrupt slice
`timescale 1ns/100ps
module pif_irq_slice_chk
    import pif_pkg::*;
(
    input wire logic        hclk,
    input wire logic        hresetn,
    input wire logic        hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0]  htrans,
    input wire logic        hwrite,
    input wire logic [31:0] hwdata,
    input wire logic        hready,
    input wire logic [31:0] hrdata,
    input wire logic        logic_cell4_event,
    input wire logic        capcomp4_event,
    input wire logic        logic_cell4_event_flag,
    input wire logic        capcomp4_event_flag,
    input wire logic [7:0]  src_flag_0,
    input wire logic [7:0]  src_flag_1,
    input wire logic [7:0]  src_flag_2,
    input wire logic [7:0]  src_flag_3,
    input wire logic [7:0]  irq_req_0,
    input wire logic [7:0]  irq_req_1,
    input wire logic [7:0]  irq_req_2,
    input wire logic [7:0]  irq_req_3,
    input wire logic        irq
);
    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);
    // ----------------------------------------------------------------
    // data-phase markers: the register moves at the end of the data phase
    // ----------------------------------------------------------------
    logic        wr_fl;
    logic        wr_any;
    logic        rd_fl;
    wire         take = hsel & hready & htrans[1];
    wire         at_fl = (haddr[7:0] == PIF_OFS_FLAGS10);
    wire [1:0]   flv = {logic_cell4_event_flag, capcomp4_event_flag};
    wire [31:0]  srcv = {src_flag_3, src_flag_2, src_flag_1, src_flag_0};
    wire [31:0]  reqv = {irq_req_3, irq_req_2, irq_req_1, irq_req_0};
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wr_fl  <= 1'b0;
            wr_any <= 1'b0;
            rd_fl  <= 1'b0;
        end else begin
            wr_fl  <= take & hwrite & at_fl;
            wr_any <= take & hwrite;
            rd_fl  <= take & !hwrite & at_fl;
        end
    end
    sequence s_clr_cc;
        wr_fl && !hwdata[PIF_CAPCOMP4_BIT] && !capcomp4_event;
    endsequence
    property p_set_cc;
        capcomp4_event |=> capcomp4_event_flag;
    endproperty
    a_set_cc: assert property (p_set_cc) else $error("capture flag missed");
    property p_set_lc;
        logic_cell4_event |=> logic_cell4_event_flag;
    endproperty
    a_set_lc: assert property (p_set_lc) else $error("logic flag missed");
    property p_hold;
        !wr_fl |=> (($past(flv) & ~flv) == 2'b00);
    endproperty
    a_hold: assert property (p_hold) else $error("flag dropped alone");
    property p_clear;
        s_clr_cc |=> !capcomp4_event_flag;
    endproperty
    a_clear: assert property (p_clear) else $error("flag not cleared");
    property p_gated;
        (reqv & ~srcv) == 32'h0;
    endproperty
    a_gated: assert property (p_gated) else $error("request without flag");
    property p_req_stable;
        !wr_any ##1 $stable(srcv) |-> $stable(reqv);
    endproperty
    a_req_stable: assert property (p_req_stable) else $error("request moved");
    property p_rd_top;
        rd_fl |-> (hrdata[31:2] == 30'h0);
    endproperty
    a_rd_top: assert property (p_rd_top) else $error("flag upper bits set");
    property p_reset;
        $rose(hresetn) |-> (flv == 2'b00) && !irq && (reqv == 32'h0);
    endproperty
    a_reset: assert property (p_reset) else $error("not zero after reset");
endmodule

bind pif_irq_slice pif_irq_slice_chk u_pif_irq_slice_chk (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hwdata(hwdata), .hready(hready), .hrdata(hrdata),
    .logic_cell4_event(logic_cell4_event), .capcomp4_event(capcomp4_event),
    .logic_cell4_event_flag(logic_cell4_event_flag),
    .capcomp4_event_flag(capcomp4_event_flag), .src_flag_0(src_flag_0),
    .src_flag_1(src_flag_1), .src_flag_2(src_flag_2), .src_flag_3(src_flag_3),
    .irq_req_0(irq_req_0), .irq_req_1(irq_req_1), .irq_req_2(irq_req_2),
    .irq_req_3(irq_req_3), .irq(irq));

/* File: verif/pif_src_model.sv */
// behavioural model of the event sources that feed the slice
`timescale 1ns/100ps
module pif_src_model (
    input  wire logic        hclk,
    input  wire logic        hresetn,
    input  wire logic [1:0]  fire,
    input  wire logic [31:0] level,
    output logic             logic_cell4_event,
    output logic             capcomp4_event,
    output logic      [7:0]  src_flag_0,
    output logic      [7:0]  src_flag_1,
    output logic      [7:0]  src_flag_2,
    output logic      [7:0]  src_flag_3
);
    // sources change just after the edge, like any same-clock logic
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            logic_cell4_event <= 1'b0;
            capcomp4_event    <= 1'b0;
            {src_flag_3, src_flag_2, src_flag_1, src_flag_0} <= 32'h0;
        end else begin
            logic_cell4_event <= fire[1];
            capcomp4_event    <= fire[0];
            {src_flag_3, src_flag_2, src_flag_1, src_flag_0} <= level;
        end
    end
endmodule

/* File: verif/tb_pif_irq_slice.sv */
// self-checking testbench of the peripheral interrupt slice
`timescale 1ns/100ps
module tb_pif_irq_slice;
    import pif_pkg::*;
    logic        hclk;
    logic        hresetn;
    logic        hsel;
    logic        hwrite;
    logic [1:0]  htrans;
    logic [1:0]  fire;
    logic [2:0]  hsize;
    logic [31:0] haddr;
    logic [31:0] hwdata;
    logic [31:0] level;
    logic [31:0] rd;
    wire         hreadyout;
    wire         hresp;
    wire  [31:0] hrdata;
    wire         lc_ev;
    wire         cc_ev;
    wire         lc_fl;
    wire         cc_fl;
    wire         irq;
    wire  [7:0]  s0, s1, s2, s3, q0, q1, q2, q3;
    wire  [31:0] reqv = {q3, q2, q1, q0};
    int          n_errors = 0;
    int          n_compared = 0;
    pif_irq_slice u_pif_irq_slice (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
        .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
        .hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
        .logic_cell4_event(lc_ev), .capcomp4_event(cc_ev), .logic_cell4_event_flag(lc_fl),
        .capcomp4_event_flag(cc_fl), .src_flag_0(s0), .src_flag_1(s1), .src_flag_2(s2),
        .src_flag_3(s3), .irq_req_0(q0), .irq_req_1(q1), .irq_req_2(q2), .irq_req_3(q3),
        .irq(irq));
    pif_src_model u_pif_src_model (.hclk(hclk), .hresetn(hresetn), .fire(fire),
        .level(level), .logic_cell4_event(lc_ev), .capcomp4_event(cc_ev),
        .src_flag_0(s0), .src_flag_1(s1), .src_flag_2(s2), .src_flag_3(s3));
    // ----------------------------------------------------------------
    // bus and checking helpers
    // ----------------------------------------------------------------
    task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
        n_compared++;
        if (seen !== exp) begin
            n_errors++;
            $display("unexpected %s: expected %h seen %h", what, exp, seen);
        end
    endtask
    // one single transfer; waits on hreadyout rather than assuming zero waits
    task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
        hsel   <= 1'b1;
        haddr  <= {24'h0, a};
        htrans <= 2'b10;
        hwrite <= w;
        @(posedge hclk);
        while (hreadyout !== 1'b1) @(posedge hclk);
        hsel   <= 1'b0;
        htrans <= 2'b00;
        hwdata <= d;
        @(posedge hclk);
        while (hreadyout !== 1'b1) @(posedge hclk);
        rd = hrdata;
    endtask
    task automatic rdchk(input string what, input logic [7:0] a, input logic [31:0] exp);
        bus(1'b0, a, 32'h0);
        chk(what, rd, exp);
    endtask
    // one-cycle event pulse, then time for the flag to land
    task automatic pulse(input logic [1:0] v);
        fire <= v;
        @(posedge hclk);
        fire <= 2'b00;
        repeat (2) @(posedge hclk);
    endtask
    function automatic logic [7:0] ea(input int k);
        return PIF_OFS_EN0 + 8'(4 * k);
    endfunction
    task automatic end_sim;
        if (n_errors == 0 && n_compared > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask
    // ----------------------------------------------------------------
    // scenarios
    // ----------------------------------------------------------------
    task automatic t_reset;
        rdchk("flags", PIF_OFS_FLAGS10, 32'h0);
        for (int k = 0; k < 4; k++) rdchk("enable", ea(k), 32'h0);
        rdchk("unmapped", 8'h1c, 32'h0);
        chk("response", hresp, 32'h0);
        chk("ready", hreadyout, 32'h1);
        chk("requests", reqv, 32'h0);
    endtask
    // walk a single one through every enable bit; junk above bit 7 must be dropped
    task automatic t_enables;
        level <= 32'h5ac3ffa5;
        for (int k = 0; k < 4; k++) begin
            for (int b = 0; b < 8; b++) begin
                bus(1'b1, ea(k), 32'hffffff00 | (32'h1 << b));
                rdchk("enable", ea(k), 32'h1 << b);
                chk("request", reqv, 32'h5ac3ffa5 & (32'h1 << (8 * k + b)));
            end
            bus(1'b1, ea(k), 32'h0);
        end
        rdchk("enable", ea(3), 32'h0);
        chk("request", reqv, 32'h0);
    endtask
    task automatic t_flags;
        pulse(2'b01);
        rdchk("flags", PIF_OFS_FLAGS10, 32'h1);
        repeat (20) @(posedge hclk);
        rdchk("flags", PIF_OFS_FLAGS10, 32'h1);
        pulse(2'b10);
        chk("flag pins", {lc_fl, cc_fl}, 32'h3);
        bus(1'b1, PIF_OFS_FLAGS10, 32'hfffffffd);
        rdchk("flags", PIF_OFS_FLAGS10, 32'h1);
        bus(1'b1, PIF_OFS_FLAGS10, 32'h0);
        rdchk("flags", PIF_OFS_FLAGS10, 32'h0);
        bus(1'b1, PIF_OFS_FLAGS10, 32'h2);
        rdchk("flags", PIF_OFS_FLAGS10, 32'h2);
        bus(1'b1, PIF_OFS_FLAGS10, 32'h0);
    endtask
    task automatic t_irq;
        // both events of the flag scenario still sit in status
        rdchk("status", PIF_OFS_STATUS, 32'h3);
        pulse(2'b01);
        chk("irq masked", irq, 32'h0);
        rdchk("status", PIF_OFS_STATUS, 32'h1);
        rdchk("status", PIF_OFS_STATUS, 32'h0);
        // the last status read emptied status, so opening the mask gives no instant interrupt
        bus(1'b1, PIF_OFS_FLAGS10, 32'h0);
        bus(1'b1, PIF_OFS_MASK, 32'h3);
        chk("irq idle", irq, 32'h0);
        pulse(2'b10);
        chk("irq", irq, 32'h1);
        rdchk("status", PIF_OFS_STATUS, 32'h2);
        chk("irq cleared", irq, 32'h0);
    endtask
    // reset in mid-run with flags, status, mask and enable register 0 armed
    task automatic t_midreset;
        bus(1'b1, ea(0), 32'hff);
        pulse(2'b11);
        hresetn <= 1'b0;
        @(posedge hclk);
        chk("flag pins", {lc_fl, cc_fl, irq}, 32'h0);
        chk("requests", reqv, 32'h0);
        hresetn <= 1'b1;
        @(posedge hclk);
        rdchk("enable", ea(0), 32'h0);
        rdchk("mask", PIF_OFS_MASK, 32'h0);
    endtask
    initial begin
        hclk = 1'b0;
        forever #50 hclk = ~hclk;
    end
    initial begin
        hresetn = 1'b0;
        hsel    = 1'b0;
        haddr   = 32'h0;
        htrans  = 2'b00;
        hwrite  = 1'b0;
        hsize   = 3'b010;
        hwdata  = 32'h0;
        fire    = 2'b00;
        level   = 32'h0;
        repeat (4) @(posedge hclk);
        hresetn <= 1'b1;
        @(posedge hclk);
        t_reset();
        t_enables();
        t_flags();
        t_irq();
        t_midreset();
        end_sim();
    end
    // the whole run needs well under a thousand cycles
    initial begin
        repeat (5000) @(posedge hclk);
        n_errors++;
        end_sim();
    end
endmodule
